// [hw/ipr_pkg.sv]
// Purpose: Constants for the paged status and coefficient register block
// Assumes: 16-bit registers, even byte addresses within a 128-byte page
// Notes:   Offsets are byte addresses within a page
package ipr_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CRC_PERIOD_MS   = 20;
  localparam int unsigned CRC_PERIOD_CYC  = CLK_HZ / 1000 * CRC_PERIOD_MS;
  localparam logic [6:0]  OFF_PAGE_SEL    = 7'h00;
  localparam logic [6:0]  OFF_SAMPLE_CNT  = 7'h04;
  localparam logic [6:0]  OFF_ERR_FLAGS   = 7'h08;
  localparam logic [6:0]  OFF_GLOBAL_CMD  = 7'h02;
  localparam logic [6:0]  OFF_PIN_FUNC    = 7'h06;
  localparam logic [6:0]  OFF_COEF_FIRST  = 7'h08;
  localparam logic [15:0] PAGE_STATUS     = 16'h0000;
  localparam logic [15:0] PAGE_CONTROL    = 16'h0003;
  localparam logic [15:0] PAGE_COEF_FIRST = 16'h0007;
  localparam logic [15:0] PAGE_COEF_LAST  = 16'h000C;
  localparam logic [15:0] PAGE_SEL_RST    = 16'h0000;
  localparam logic [15:0] SAMPLE_CNT_RST  = 16'h0000;
  localparam logic [15:0] ERR_FLAGS_RST   = 16'h0000;
  localparam logic [15:0] PIN_FUNC_RST    = 16'h000D;
  localparam int unsigned COEF_PER_PAGE   = 60;
  localparam int unsigned COEF_PER_BANK   = 120;
  localparam int unsigned COEF_BANKS      = 3;
  localparam int unsigned COEF_WORDS      = COEF_BANKS * COEF_PER_BANK;
  localparam int unsigned BIT_WATCHDOG    = 15;
  localparam int unsigned BIT_SYNC        = 8;
  localparam int unsigned BIT_OVERRUN     = 7;
  localparam int unsigned BIT_FLASH       = 6;
  localparam int unsigned BIT_SELF_TEST   = 5;
  localparam int unsigned BIT_SPI_FRAME   = 3;
  localparam int unsigned BIT_SRAM_CRC    = 2;
  localparam int unsigned BIT_BOOT        = 1;
  localparam int unsigned BIT_SYNC_ENABLE = 8;
  localparam int unsigned BIT_CMD_FLASH   = 3;
  localparam int unsigned BIT_CMD_SELF    = 1;
  localparam logic [15:0] ERR_USED_MASK   = 16'h81EE;
  localparam logic [15:0] ERR_KEEP_MASK   = 16'h0080;
  localparam int unsigned SPI_WORD_BITS   = 16;
endpackage : ipr_pkg

// [hw/ipr_regs.sv]
// Purpose: Paged user registers: page select, sample counter, error flags,
//          global command, pin function control, filter banks B to D
// Assumes: Word accesses arrive already deserialised from the serial port
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module ipr_regs
  import ipr_pkg::*;
#(
  parameter int unsigned CRC_PERIOD = ipr_pkg::CRC_PERIOD_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic        spi_sclk_pulse_i,
  input  wire logic        spi_frame_end_i,
  input  wire logic        data_update_i,
  input  wire logic        watchdog_reset_i,
  input  wire logic        sync_scale_err_i,
  input  wire logic        overrun_i,
  input  wire logic        flash_update_fail_i,
  input  wire logic        self_test_fail_i,
  input  wire logic        in_motion_i,
  input  wire logic        sram_crc_done_i,
  input  wire logic        sram_crc_fail_i,
  input  wire logic        boot_backup_i,
  input  wire logic [8:0]  coef_sel_i,
  output logic      [15:0] coef_o,
  output logic      [15:0] page_select_o,
  output logic      [15:0] pin_function_o,
  output logic             flash_update_start_o,
  output logic             self_test_start_o,
  output logic             sram_crc_start_o
);
  import ipr_pkg::*;

  logic [15:0] page_q, page_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] err_q, err_d;
  logic [15:0] pin_q, pin_d;
  logic [15:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic        fl_q, fl_d, st_q, st_d, crc_q, crc_d;
  logic [3:0]  bits_q, bits_d;
  logic [31:0] tmr_q, tmr_d;
  logic [15:0] coef_q;
  logic [15:0] coef_mem [COEF_WORDS];
  logic [15:0] set_ev;
  logic        is_coef, rd_err;
  logic [8:0]  coef_idx;

  // Maps page and byte offset to a flat coefficient index
  function automatic logic [8:0] coef_index(input logic [15:0] page, input logic [6:0] addr);
    logic [3:0] rel;
    logic [8:0] word;
    rel  = 4'(page - PAGE_COEF_FIRST);
    word = 9'((addr - OFF_COEF_FIRST) >> 1);
    return 9'(rel[3:1] * COEF_PER_BANK) + 9'(rel[0] * COEF_PER_PAGE) + word;
  endfunction : coef_index

  // One register of one page; keeps page and offset decoding in one place
  function automatic logic reg_at(input logic [15:0] page, input logic [6:0] addr,
                                  input logic [15:0] want_page, input logic [6:0] want_off);
    return (page == want_page) && (addr == want_off);
  endfunction : reg_at

  assign is_coef  = (page_q >= PAGE_COEF_FIRST) && (page_q <= PAGE_COEF_LAST)
                    && (reg_addr_i >= OFF_COEF_FIRST);
  assign coef_idx = coef_index(page_q, reg_addr_i);
  assign rd_err   = reg_rd_i && reg_at(page_q, reg_addr_i, PAGE_STATUS, OFF_ERR_FLAGS);

  // Causes are levels, so a persistent fault sets again after a read
  always_comb begin
    set_ev                = '0;
    set_ev[BIT_WATCHDOG]  = watchdog_reset_i;
    set_ev[BIT_SYNC]      = sync_scale_err_i && pin_q[BIT_SYNC_ENABLE];
    set_ev[BIT_OVERRUN]   = overrun_i;
    set_ev[BIT_FLASH]     = flash_update_fail_i;
    set_ev[BIT_SELF_TEST] = self_test_fail_i && !in_motion_i;
    set_ev[BIT_SPI_FRAME] = spi_frame_end_i
                            && ((spi_sclk_pulse_i ? bits_q + 4'h1 : bits_q) != 4'h0);
    set_ev[BIT_SRAM_CRC]  = sram_crc_done_i && sram_crc_fail_i;
    set_ev[BIT_BOOT]      = boot_backup_i;
  end

  always_comb begin
    page_d   = page_q;
    cnt_d    = data_update_i ? cnt_q + 16'h0001 : cnt_q;
    err_d    = rd_err ? (err_q & ERR_KEEP_MASK) : err_q;
    err_d    = (err_d | set_ev) & ERR_USED_MASK;
    pin_d    = pin_q;
    fl_d     = 1'b0;
    st_d     = 1'b0;
    rvalid_d = reg_rd_i;
    rdata_d  = rdata_q;
    bits_d   = spi_frame_end_i ? 4'h0 : (spi_sclk_pulse_i ? bits_q + 4'h1 : bits_q);
    tmr_d    = (tmr_q == 32'(CRC_PERIOD - 1)) ? 32'h0 : tmr_q + 32'h1;
    crc_d    = (tmr_q == 32'(CRC_PERIOD - 1));
    if (reg_wr_i) begin
      if (reg_addr_i == OFF_PAGE_SEL) begin
        page_d = reg_wdata_i;
      end else if (reg_at(page_q, reg_addr_i, PAGE_CONTROL, OFF_PIN_FUNC)) begin
        pin_d = reg_wdata_i;
      end else if (reg_at(page_q, reg_addr_i, PAGE_CONTROL, OFF_GLOBAL_CMD)) begin
        fl_d = reg_wdata_i[BIT_CMD_FLASH];
        st_d = reg_wdata_i[BIT_CMD_SELF];
      end
    end
    if (reg_rd_i) begin
      rdata_d = 16'h0000;
      if (reg_addr_i == OFF_PAGE_SEL) begin
        rdata_d = page_q;
      end else if (reg_at(page_q, reg_addr_i, PAGE_STATUS, OFF_SAMPLE_CNT)) begin
        rdata_d = cnt_q;
      end else if (rd_err) begin
        rdata_d = err_q;
      end else if (reg_at(page_q, reg_addr_i, PAGE_CONTROL, OFF_PIN_FUNC)) begin
        rdata_d = pin_q;
      end else if (is_coef) begin
        rdata_d = coef_mem[coef_idx];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      page_q   <= PAGE_SEL_RST;
      cnt_q    <= SAMPLE_CNT_RST;
      err_q    <= ERR_FLAGS_RST;
      pin_q    <= PIN_FUNC_RST;
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
      fl_q     <= 1'b0;
      st_q     <= 1'b0;
      crc_q    <= 1'b0;
      bits_q   <= 4'h0;
      tmr_q    <= 32'h0;
    end else begin
      page_q   <= page_d;
      cnt_q    <= cnt_d;
      err_q    <= err_d;
      pin_q    <= pin_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      fl_q     <= fl_d;
      st_q     <= st_d;
      crc_q    <= crc_d;
      bits_q   <= bits_d;
      tmr_q    <= tmr_d;
    end
  end

  // Coefficient storage has no reset; contents come only from host register writes
  always_ff @(posedge ref_clk_i) begin
    if (reg_wr_i && is_coef) begin
      coef_mem[coef_idx] <= reg_wdata_i;
    end
    coef_q <= coef_mem[coef_sel_i];
  end

  assign reg_rdata_o          = rdata_q;
  assign reg_rvalid_o         = rvalid_q;
  assign page_select_o        = page_q;
  assign pin_function_o       = pin_q;
  assign flash_update_start_o = fl_q;
  assign self_test_start_o    = st_q;
  assign sram_crc_start_o     = crc_q;
  assign coef_o               = coef_q;

  // Checks
  page_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    reg_wr_i && reg_addr_i == OFF_PAGE_SEL |=> page_select_o == $past(reg_wdata_i))
    else $error("page select not loaded");
  page_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(reg_wr_i && reg_addr_i == OFF_PAGE_SEL) |=> $stable(page_select_o))
    else $error("page select changed without write");
  page_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == OFF_PAGE_SEL && !reg_wr_i
    |=> reg_rvalid_o && reg_rdata_o == page_select_o)
    else $error("page read wrong");
  read_answer_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    1'b1 |=> reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer not one cycle after strobe");
  rdata_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  coef_readback_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    reg_wr_i && is_coef && !reg_rd_i ##1 reg_rd_i && !reg_wr_i
    && $stable(reg_addr_i) && $stable(page_q)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("coefficient readback wrong");
  reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    reg_rd_i && page_q >= PAGE_COEF_FIRST && page_q <= PAGE_COEF_LAST
    && reg_addr_i > OFF_PAGE_SEL && reg_addr_i < OFF_COEF_FIRST
    |=> reg_rdata_o == 16'h0000)
    else $error("reserved offset not zero");
  count_step_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    data_update_i |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
    else $error("sample counter did not step");
  count_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !data_update_i |=> $stable(cnt_q))
    else $error("sample counter moved without update");
  count_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    data_update_i && cnt_q == 16'hFFFF |=> cnt_q == 16'h0000)
    else $error("sample counter did not wrap");
  watchdog_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    watchdog_reset_i |=> err_q[BIT_WATCHDOG])
    else $error("watchdog flag missed");
  sync_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    sync_scale_err_i && pin_q[BIT_SYNC_ENABLE] |=> err_q[BIT_SYNC])
    else $error("sync flag missed");
  sync_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (!sync_scale_err_i || !pin_q[BIT_SYNC_ENABLE]) && rd_err |=> !err_q[BIT_SYNC])
    else $error("sync flag without enabled cause");
  pin_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    reg_wr_i && reg_at(page_q, reg_addr_i, PAGE_CONTROL, OFF_PIN_FUNC)
    |=> pin_function_o == $past(reg_wdata_i))
    else $error("pin function not loaded");
  overrun_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    overrun_i |=> err_q[BIT_OVERRUN])
    else $error("overrun flag missed");
  overrun_keep_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    err_q[BIT_OVERRUN] |=> err_q[BIT_OVERRUN])
    else $error("overrun flag lost");
  flash_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    flash_update_fail_i |=> err_q[BIT_FLASH])
    else $error("flash flag missed");
  cmd_start_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    reg_wr_i && reg_at(page_q, reg_addr_i, PAGE_CONTROL, OFF_GLOBAL_CMD)
    |=> flash_update_start_o == $past(reg_wdata_i[BIT_CMD_FLASH])
    && self_test_start_o == $past(reg_wdata_i[BIT_CMD_SELF]))
    else $error("command start pulse wrong");
  start_idle_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(reg_wr_i && reg_at(page_q, reg_addr_i, PAGE_CONTROL, OFF_GLOBAL_CMD))
    |=> !flash_update_start_o && !self_test_start_o)
    else $error("start pulse without command");
  self_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    self_test_fail_i && !in_motion_i |=> err_q[BIT_SELF_TEST])
    else $error("self test flag missed");
  self_test_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    self_test_fail_i && in_motion_i && rd_err |=> !err_q[BIT_SELF_TEST])
    else $error("self test flag set in motion");
  frame_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    spi_frame_end_i && !spi_sclk_pulse_i && bits_q != 4'h0 |=> err_q[BIT_SPI_FRAME])
    else $error("framing flag missed");
  crc_tick_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    sram_crc_start_o |=> !sram_crc_start_o [*2])
    else $error("CRC start not a single pulse");

  // Spacing between CRC starts, counted apart from the period timer
  logic [31:0] gap_q, gap_d;
  logic        gap_seen_q, gap_seen_d;
  always_comb begin
    gap_d      = sram_crc_start_o ? 32'h0 : gap_q + 32'h1;
    gap_seen_d = gap_seen_q || sram_crc_start_o;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      gap_q      <= 32'h0;
      gap_seen_q <= 1'b0;
    end else begin
      gap_q      <= gap_d;
      gap_seen_q <= gap_seen_d;
    end
  end
  crc_period_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    sram_crc_start_o && gap_seen_q |-> gap_q == 32'(CRC_PERIOD - 1))
    else $error("CRC start spacing wrong");
  crc_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    sram_crc_done_i && sram_crc_fail_i |=> err_q[BIT_SRAM_CRC])
    else $error("SRAM CRC flag missed");
  boot_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    boot_backup_i |=> err_q[BIT_BOOT])
    else $error("boot flag missed");
  read_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_err && set_ev == 16'h0000 |=> (err_q & ~ERR_KEEP_MASK) == 16'h0000
    && reg_rdata_o == $past(err_q))
    else $error("flags not cleared by read");
  err_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !rd_err && set_ev == 16'h0000 |=> $stable(err_q))
    else $error("flags changed without cause or read");
  unused_zero_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (err_q & ~ERR_USED_MASK) == 16'h0000)
    else $error("unused flag bit set");

  cov_frame_err_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    spi_frame_end_i ##1 err_q[BIT_SPI_FRAME]);
  cov_read_clear_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_err && err_q != 16'h0000 ##1 err_q == 16'h0000);
  cov_count_wrap_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    data_update_i && cnt_q == 16'hFFFF);
  cov_coef_write_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    reg_wr_i && is_coef && page_q == PAGE_COEF_LAST);
  cov_cmd_start_c: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
    flash_update_start_o && self_test_start_o);
endmodule : ipr_regs

`default_nettype wire

// [sim/ipr_host_model.sv]
// Purpose: Host serial framing model, one pulse per serial clock seen
// Assumes: go_i is high for one cycle while nbits_i is steady
// Notes:   Serial clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module ipr_host_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [5:0] nbits_i,
  output var  logic       sclk_pulse_o,
  output var  logic       frame_end_o
);
  initial begin
    sclk_pulse_o = 1'b0;
    frame_end_o  = 1'b0;
  end
  always begin
    @(posedge clk_i iff go_i);
    repeat (nbits_i) begin
      #1 sclk_pulse_o = 1'b1;
      @(posedge clk_i);
    end
    #1 sclk_pulse_o = 1'b0;
    frame_end_o = 1'b1;
    @(posedge clk_i);
    #1 frame_end_o = 1'b0;
  end
endmodule : ipr_host_model
`default_nettype wire

// [sim/ipr_regs_tb.sv]
// Purpose: Self-checking bench for the paged register block
// Assumes: Short sram check period, inputs driven 1 ns after the edge
// Notes:   Counter wrap costs about 65k cycles, hence the long ceiling
`timescale 1ns/1ps
`default_nettype none
module ipr_regs_tb;
  import ipr_pkg::*;
  localparam int unsigned CRC_SIM = 10;
  typedef struct packed {
    logic [15:0] page;
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } ipr_row_t;
  logic        ref_clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, upd = 1'b0;
  logic        motion = 1'b0, go = 1'b0, rvalid, fst, sst, cst, sclk, fend;
  logic [6:0]  addr = 7'h00, cause = 7'h00;
  logic [15:0] wdata = 16'h0000, rdata, coef, page, pinf;
  logic [8:0]  csel = 9'h000;
  logic [5:0]  nbits = 6'h08;
  int          err_count = 0, checks_done = 0, cyc = 0, n = 0;
  int          fbit [7] = '{15, 8, 6, 5, 2, 1, 7};
  ipr_row_t    rows [7] = '{'{16'h0007, 7'h08, 16'h1234, 16'h1234},
    '{16'h0008, 7'h7E, 16'hBEEF, 16'hBEEF}, '{16'h000C, 7'h7E, 16'h5A5A, 16'h5A5A},
    '{16'h0009, 7'h04, 16'hFFFF, 16'h0000}, '{16'h0005, 7'h00, 16'h0005, 16'h0005},
    '{16'h0003, 7'h06, 16'h0100, 16'h0100}, '{16'h0000, 7'h7E, 16'h1111, 16'h0000}};
  ipr_regs #(.CRC_PERIOD(CRC_SIM)) uut (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .spi_sclk_pulse_i(sclk),
    .spi_frame_end_i(fend), .data_update_i(upd), .watchdog_reset_i(cause[0]),
    .sync_scale_err_i(cause[1]), .overrun_i(cause[6]), .flash_update_fail_i(cause[2]),
    .self_test_fail_i(cause[3]), .in_motion_i(motion), .sram_crc_done_i(cause[4]),
    .sram_crc_fail_i(cause[4]), .boot_backup_i(cause[5]), .coef_sel_i(csel),
    .coef_o(coef), .page_select_o(page), .pin_function_o(pinf),
    .flash_update_start_o(fst), .self_test_start_o(sst), .sram_crc_start_o(cst));
  ipr_host_model host (.clk_i(ref_clk), .go_i(go), .nbits_i(nbits),
    .sclk_pulse_o(sclk), .frame_end_o(fend));
  always #20 ref_clk = ~ref_clk;
  task automatic end_sim;
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge ref_clk);
    #1 wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [6:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge ref_clk);
    #1 rd = 1'b0;
    chk({15'h0000, rvalid}, 16'h0001);
    chk(rdata, exp);
  endtask : rd_reg
  task automatic pulse(input int i);
    @(posedge ref_clk);
    #1 cause[i] = 1'b1;
    @(posedge ref_clk);
    #1 cause[i] = 1'b0;
  endtask : pulse
  task automatic frame(input logic [5:0] bits);
    @(posedge ref_clk);
    #1 nbits = bits;
    go = 1'b1;
    @(posedge ref_clk);
    #1 go = 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask : frame
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 resetn = 1'b1;
    rd_reg(OFF_PAGE_SEL, PAGE_SEL_RST);
    rd_reg(OFF_SAMPLE_CNT, SAMPLE_CNT_RST);
    rd_reg(OFF_ERR_FLAGS, ERR_FLAGS_RST);
    foreach (rows[i]) begin
      wr_reg(OFF_PAGE_SEL, rows[i].page);
      wr_reg(rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].addr, rows[i].exp);
      chk(page, rows[i].page);
    end
    chk(pinf, 16'h0100);
    csel = 9'h167;
    @(posedge ref_clk);
    #1 chk(coef, 16'h5A5A);
    csel = 9'h077;
    @(posedge ref_clk);
    #1 chk(coef, 16'hBEEF);
    wr_reg(OFF_PAGE_SEL, 16'h000B);
    @(posedge ref_clk);
    #1 addr = 7'h0A;
    wdata = 16'hC0DE;
    wr = 1'b1;
    @(posedge ref_clk);
    #1 wr = 1'b0;
    rd = 1'b1;
    @(posedge ref_clk);
    #1 rd = 1'b0;
    chk(rdata, 16'hC0DE);
    wr_reg(OFF_PAGE_SEL, PAGE_CONTROL);
    wr_reg(OFF_GLOBAL_CMD, 16'h000A);
    chk({14'h0000, fst, sst}, 16'h0003);
    wr_reg(OFF_PAGE_SEL, PAGE_STATUS);
    foreach (fbit[i]) begin
      pulse(i);
      rd_reg(OFF_ERR_FLAGS, 16'(1 << fbit[i]));
      rd_reg(OFF_ERR_FLAGS, (i == 6) ? ERR_KEEP_MASK : 16'h0000);
    end
    motion = 1'b1;
    pulse(3);
    rd_reg(OFF_ERR_FLAGS, 16'h0080);
    motion = 1'b0;
    cause[0] = 1'b1;
    rd_reg(OFF_ERR_FLAGS, 16'h8080);
    rd_reg(OFF_ERR_FLAGS, 16'h8080);
    cause[0] = 1'b0;
    rd_reg(OFF_ERR_FLAGS, 16'h8080);
    rd_reg(OFF_ERR_FLAGS, 16'h0080);
    frame(6'h08);
    rd_reg(OFF_ERR_FLAGS, 16'h0088);
    frame(6'h10);
    rd_reg(OFF_ERR_FLAGS, 16'h0080);
    repeat (100) begin
      @(posedge ref_clk);
      #1 n += int'(cst);
    end
    chk(16'(n), 16'(100 / CRC_SIM));
    @(posedge ref_clk);
    #1 upd = 1'b1;
    repeat (65535) @(posedge ref_clk);
    #1 upd = 1'b0;
    rd_reg(OFF_SAMPLE_CNT, 16'hFFFF);
    @(posedge ref_clk);
    #1 upd = 1'b1;
    @(posedge ref_clk);
    #1 upd = 1'b0;
    rd_reg(OFF_SAMPLE_CNT, 16'h0000);
    @(posedge ref_clk);
    #1 resetn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 resetn = 1'b1;
    chk(pinf, PIN_FUNC_RST);
    rd_reg(OFF_ERR_FLAGS, ERR_FLAGS_RST);
    end_sim();
  end
endmodule : ipr_regs_tb
`default_nettype wire
